// *** hw/srw_filter.sv ***
// low-pulse filter: output falls only after input low for a run of cycles
module srw_filter #(
	parameter int unsigned RUN = 3
) (
	input  wire logic clk_sys,  // time base
	input  wire logic sys_rst,  // async reset, high
	input  wire logic lvlIn,    // synchronised level, active low
	output logic      lvlOut    // filtered level, active low
);
	localparam int unsigned CW = $clog2(RUN + 1);
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          q;
	} srw_filter_s;
	srw_filter_s st_r;
	srw_filter_s st_nxt;
	always_comb begin
		st_nxt = st_r;
		if (lvlIn) begin
			st_nxt.cnt = '0;
			st_nxt.q   = 1'b1;
		end else if (st_r.cnt >= CW'(RUN)) begin
			st_nxt.q = 1'b0;
		end else begin
			st_nxt.cnt = st_r.cnt + CW'(1);
		end
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= '{cnt: '0, q: 1'b1};
		end else begin
			st_r <= st_nxt;
		end
	end
	assign lvlOut = st_r.q;
endmodule

// *** hw/srw_pkg.sv ***
// shared constants for the supervisory reset watchdog
package srw_pkg;
	// ****************************************
	// clock and time base
	// ****************************************
	localparam int unsigned CLK_HZ          = 25000000;
	localparam int unsigned CLK_NS          = 40;
	// reset hold period, least time in ms (exact, no rounding)
	localparam int unsigned HOLD_MS         = 140;
	localparam int unsigned HOLD_CYC        = HOLD_MS * (CLK_HZ / 1000);
	// watchdog period nominal, in ms (least 1120, most 2400)
	localparam int unsigned WDOG_MS         = 1600;
	localparam int unsigned WDOG_CYC        = WDOG_MS * (CLK_HZ / 1000);
	// manual reset glitch rejection, least ns (rounds up)
	localparam int unsigned GLITCH_NS       = 100;
	localparam int unsigned GLITCH_CYC      = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
	// manual reset least pulse that must act, ns
	localparam int unsigned MRPULSE_NS      = 1000;
	localparam int unsigned MRPULSE_CYC     = MRPULSE_NS / CLK_NS;
	// watchdog input least pulse, ns
	localparam int unsigned WDPULSE_NS      = 50;
	localparam int unsigned WDPULSE_CYC     = (WDPULSE_NS + CLK_NS - 1) / CLK_NS;
	// ****************************************
	// reset values
	// ****************************************
	localparam logic        RST_SYNC_VAL    = 1'b1;
	localparam logic        RST_UV_VAL      = 1'b1;
	localparam logic        RST_ASSERT_VAL  = 1'b1;
endpackage

// *** hw/srw_supervisor.sv ***
// supervisory reset generator with manual reset and watchdog
module srw_supervisor
	import srw_pkg::*;
#(
	parameter int unsigned HOLD_CYCLES = srw_pkg::HOLD_CYC,  // reset hold period
	parameter int unsigned WDOG_CYCLES = srw_pkg::WDOG_CYC,  // watchdog period
	parameter int unsigned MR_RUN      = srw_pkg::GLITCH_CYC // manual glitch filter
) (
	input  wire logic clk_sys,                // 25 MHz time base
	input  wire logic sys_rst,                // async reset, high
	input  wire logic primarySupplyLow,       // primary supply undervoltage flag
	input  wire logic secondarySupplyLow,     // secondary supply undervoltage flag
	input  wire logic adjustMonitorLow,       // adjustable monitor undervoltage flag
	input  wire logic manualResetIn,          // manual reset pin level, low = reset
	input  wire logic manualResetPullOe,      // manual pin is driven externally
	input  wire logic watchdogKickIn,         // watchdog input pin level
	input  wire logic watchdogKickOe,         // watchdog pin is driven externally
	input  wire logic openDrainSel,           // strap: 1 open-drain low output
	output logic      resetHighOut,           // active-high reset output
	output logic      resetLowOut,            // active-low reset output level
	output logic      resetLowOe,             // active-low output enable
	output logic      watchdogFired           // pulse: watchdog expiry seen
);
	import srw_pkg::*;

	localparam int unsigned HW = $clog2(HOLD_CYCLES + 1);
	localparam int unsigned WW = $clog2(WDOG_CYCLES + 1);

	// ****************************************
	// input conditioning
	// ****************************************
	logic mrPin;
	logic wdPin;
	logic wdEn;
	logic mrSync;
	logic mrFilt;
	logic wdSync;
	logic uvSync;
	logic wdEnSync;
	logic uvAny;

	// an undriven manual input reads as pulled high
	// pullup on open pin
	assign mrPin = manualResetPullOe ? manualResetIn : 1'b1;
	assign wdEn  = watchdogKickOe;
	assign wdPin = watchdogKickIn;
	assign uvAny = primarySupplyLow | secondarySupplyLow | adjustMonitorLow;

	srw_sync #(.RESET_VAL(RST_SYNC_VAL)) uMrSync (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.asyncIn (mrPin),
		.syncOut (mrSync)
	);
	srw_sync #(.RESET_VAL(1'b0)) uWdSync (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.asyncIn (wdPin),
		.syncOut (wdSync)
	);
	srw_sync #(.RESET_VAL(RST_UV_VAL)) uUvSync (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.asyncIn (uvAny),
		.syncOut (uvSync)
	);
	srw_sync #(.RESET_VAL(1'b0)) uWdEnSync (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.asyncIn (wdEn),
		.syncOut (wdEnSync)
	);

	// glitches under 100ns never reach reset
	srw_filter #(.RUN(MR_RUN)) uMrFilt (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.lvlIn   (mrSync),
		.lvlOut  (mrFilt)
	);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic          inRst;
		logic [HW-1:0] holdCnt;
		logic [WW-1:0] wdCnt;
		logic          wdPrev;
		logic          wdFire;
		logic          odSel;
		logic          strapDone;
		logic          rstHi;
		logic          rstLo;
		logic          rstOe;
	} srw_state_s;

	srw_state_s st_r;
	srw_state_s st_nxt;

	logic mrActive;
	logic wdEdge;
	logic wdExpire;
	logic cause;
	assign mrActive = ~mrFilt;
	assign wdEdge   = wdSync ^ st_r.wdPrev;
	// expiry when count reaches one less than the period
	assign wdExpire = wdEnSync & ~st_r.inRst & (st_r.wdCnt >= WW'(WDOG_CYCLES - 1)) & ~wdEdge;
	assign cause    = uvSync | mrActive | wdExpire;

	always_comb begin
		st_nxt        = st_r;
		st_nxt.wdPrev = wdSync;
		st_nxt.wdFire = wdExpire;
		// strap caught once after release of reset
		if (!st_r.strapDone) begin
			st_nxt.odSel     = openDrainSel;
			st_nxt.strapDone = 1'b1;
		end
		// hold counter restarts while any cause present
		// late causes restart the same counter
		// manual low keeps restarting the hold
		// watchdog expiry starts one full hold
		if (cause) begin
			st_nxt.inRst   = 1'b1;
			st_nxt.holdCnt = '0;
		end else if (st_r.inRst) begin
			if (st_r.holdCnt >= HW'(HOLD_CYCLES - 1)) begin
				st_nxt.inRst = 1'b0;
			end else begin
				st_nxt.holdCnt = st_r.holdCnt + HW'(1);
			end
		end
		// any settled level change is an edge
		if (st_r.inRst || mrActive || wdEdge || !wdEnSync || cause) begin
			st_nxt.wdCnt = '0;
		end else begin
			st_nxt.wdCnt = st_r.wdCnt + WW'(1);
		end
		st_nxt.rstHi = st_nxt.inRst;
		// open-drain releases when not in reset
		st_nxt.rstLo = ~st_nxt.inRst;
		st_nxt.rstOe = st_nxt.odSel ? st_nxt.inRst : 1'b1;
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= '{inRst: RST_ASSERT_VAL, holdCnt: '0, wdCnt: '0, wdPrev: 1'b0,
				wdFire: 1'b0, odSel: 1'b0, strapDone: 1'b0, rstHi: 1'b1,
				rstLo: 1'b0, rstOe: 1'b1};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign resetHighOut  = st_r.rstHi;
	assign resetLowOut   = st_r.rstLo;
	assign resetLowOe    = st_r.rstOe;
	assign watchdogFired = st_r.wdFire;

	// ****************************************
	// checks
	// ****************************************
	sequence causeGone;
		!cause && st_r.inRst;
	endsequence
	sequence releaseSeen;
		!st_r.inRst;
	endsequence

	chk_out_polarity: assert property (@(posedge clk_sys) disable iff (sys_rst)
		resetHighOut == ~resetLowOut)
		else $error("reset outputs disagree");
	chk_cause_asserts: assert property (@(posedge clk_sys) disable iff (sys_rst)
		cause |=> st_r.inRst)
		else $error("cause did not assert reset");
	chk_hold_length: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$fell(st_r.inRst) |-> $past(st_r.holdCnt) == HW'(HOLD_CYCLES - 1))
		else $error("reset released before hold end");
	chk_hold_restart: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(st_r.inRst && cause) |=> st_r.holdCnt == '0)
		else $error("hold not restarted by cause");
	chk_release_seq: assert property (@(posedge clk_sys) disable iff (sys_rst)
		causeGone ##1 releaseSeen |-> $past(st_r.holdCnt) >= HW'(HOLD_CYCLES - 1))
		else $error("early release");
	chk_manual_holds: assert property (@(posedge clk_sys) disable iff (sys_rst)
		mrActive |=> st_r.inRst ##1 st_r.inRst)
		else $error("manual reset not held");
	chk_wd_cleared: assert property (@(posedge clk_sys) disable iff (sys_rst)
		st_r.inRst |=> st_r.wdCnt == '0)
		else $error("watchdog counted in reset");
	chk_wd_disabled: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!wdEnSync |=> st_r.wdCnt == '0 && !watchdogFired)
		else $error("disabled watchdog fired");
	chk_wd_edge_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wdEdge |=> st_r.wdCnt == '0)
		else $error("edge did not clear watchdog");
	chk_od_release: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(st_r.odSel && !st_r.inRst && st_r.strapDone) |-> !resetLowOe)
		else $error("open-drain output driven high");

	// ****************************************
	// checks: counters, causes and outputs
	// ****************************************
	sequence wdRunning;
		!st_r.inRst && wdEnSync && !wdEdge && !mrActive && !cause;
	endsequence
	sequence holdRunning;
		st_r.inRst && !cause && (st_r.holdCnt < HW'(HOLD_CYCLES - 1));
	endsequence

	chk_wd_period: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wdExpire |-> st_r.wdCnt == WW'(WDOG_CYCLES - 1))
		else $error("watchdog expired off period");

	chk_wd_fire_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wdExpire |=> watchdogFired && st_r.inRst && st_r.holdCnt == '0)
		else $error("watchdog expiry did not start hold");

	chk_fire_single: assert property (@(posedge clk_sys) disable iff (sys_rst)
		watchdogFired |=> !watchdogFired)
		else $error("watchdog pulse too long");

	chk_uv_cause: assert property (@(posedge clk_sys) disable iff (sys_rst)
		uvSync |=> resetHighOut && !resetLowOut)
		else $error("undervoltage did not reset");

	chk_manual_cause: assert property (@(posedge clk_sys) disable iff (sys_rst)
		mrActive |=> resetHighOut && !resetLowOut)
		else $error("manual low did not reset");

	chk_wd_counts: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wdRunning |=> st_r.wdCnt == $past(st_r.wdCnt) + WW'(1))
		else $error("watchdog did not count");

	chk_hold_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
		holdRunning |=> st_r.inRst && st_r.holdCnt == $past(st_r.holdCnt) + HW'(1))
		else $error("hold did not count");

	chk_od_drive: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(st_r.inRst && st_r.strapDone) |-> resetLowOe && !resetLowOut)
		else $error("low output not driven in reset");

	chk_pushpull_oe: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(!st_r.odSel && st_r.strapDone) |-> resetLowOe)
		else $error("push-pull output released");

	chk_strap_held: assert property (@(posedge clk_sys) disable iff (sys_rst)
		st_r.strapDone |=> $stable(st_r.odSel) && st_r.strapDone)
		else $error("output strap changed");

	chk_mr_filter: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$fell(mrFilt) |-> !$past(mrSync) && !$past(mrSync, 2))
		else $error("manual glitch passed filter");

	chk_release_clean: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$fell(st_r.inRst) |-> !$past(mrActive) && !$past(uvSync))
		else $error("released with cause present");

	chk_uv_restart: assert property (@(posedge clk_sys) disable iff (sys_rst)
		uvSync |=> st_r.holdCnt == '0)
		else $error("undervoltage did not restart hold");

	chk_mr_restart: assert property (@(posedge clk_sys) disable iff (sys_rst)
		mrActive |=> st_r.inRst && st_r.holdCnt == '0)
		else $error("manual low did not restart hold");

	chk_wd_clear_mr: assert property (@(posedge clk_sys) disable iff (sys_rst)
		mrActive |=> st_r.wdCnt == '0)
		else $error("manual reset did not clear watchdog");

	chk_sync_delay: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$rose(uvSync) |-> $past(uvAny, 3) && $past(uvAny, 4))
		else $error("supply flag passed unsynchronised");

	chk_wd_after_rel: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$fell(st_r.inRst) |-> st_r.wdCnt == '0)
		else $error("watchdog not cleared at release");
endmodule

// *** hw/srw_sync.sv ***
// three-stage synchroniser with agreement of stages two and three
module srw_sync #(
	parameter logic RESET_VAL = 1'b1
) (
	input  wire logic clk_sys,  // time base
	input  wire logic sys_rst,  // async reset, high
	input  wire logic asyncIn,  // pin level
	output logic      syncOut   // settled level
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} srw_sync_s;
	srw_sync_s st_r;
	srw_sync_s st_nxt;
	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = asyncIn;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		// s1 feeds only s2; change accepted when s2 and s3 agree
		if (st_r.s2 == st_r.s3) begin
			st_nxt.q = st_r.s3;
		end
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= {4{RESET_VAL}};
		end else begin
			st_r <= st_nxt;
		end
	end
	assign syncOut = st_r.q;
endmodule

// *** sim/srw_cpu_model.sv ***
// processor-side model that services the watchdog pin
module srw_cpu_model (
	input  wire logic       clk_sys,        // time base
	input  wire logic       inReset,        // processor held in reset
	input  wire logic       kickOn,         // firmware alive and servicing
	input  wire logic       pinDriven,      // pin driven, else three-stated
	input  wire logic [7:0] kickGap,        // cycles between toggles
	output logic            watchdogKickIn, // pin level
	output logic            watchdogKickOe  // pin driven
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt = 8'h00;
	logic       oePrev = 1'b1;
	initial watchdogKickIn = 1'b0;
	assign watchdogKickOe = pinDriven;
	always @(posedge clk_sys) begin
		oePrev <= pinDriven;
		if (!pinDriven) begin
			// released pin drifts once, then sits: a stale level is never trusted
			if (oePrev) watchdogKickIn <= ~watchdogKickIn;
		end else if (inReset || !kickOn) begin
			cnt <= 8'h00;
		end else if (cnt >= kickGap) begin
			cnt <= 8'h00;
			watchdogKickIn <= ~watchdogKickIn;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the supervisory reset watchdog
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	// short counts keep the run brief
	localparam int HOLD = 20;
	localparam int WDOG = 50;
	localparam int MRR  = 3;
	logic       clk_sys, sys_rst, mrIn, mrOe, odSel, kickOn, kickDrv;
	logic [2:0] uv;
	logic [7:0] gap;
	logic       rHi, rLo, rOe, wFired, kIn, kOe;
	int         n_mismatch = 0;
	int         samples_checked = 0;
	int         seed = 15;
	int         fired = 0;

	srw_supervisor #(.HOLD_CYCLES(HOLD), .WDOG_CYCLES(WDOG), .MR_RUN(MRR)) uut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .primarySupplyLow(uv[0]),
		.secondarySupplyLow(uv[1]), .adjustMonitorLow(uv[2]), .manualResetIn(mrIn),
		.manualResetPullOe(mrOe), .watchdogKickIn(kIn), .watchdogKickOe(kOe),
		.openDrainSel(odSel), .resetHighOut(rHi), .resetLowOut(rLo),
		.resetLowOe(rOe), .watchdogFired(wFired));
	srw_cpu_model cpu (.clk_sys(clk_sys), .inReset(rHi), .kickOn(kickOn),
		.pinDriven(kickDrv), .kickGap(gap), .watchdogKickIn(kIn), .watchdogKickOe(kOe));

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// ****
	// helpers
	// ****
	task automatic chk(input int got, input int exp, input int tol);
		samples_checked++;
		if (got > exp + tol || got < exp - tol) begin
			n_mismatch++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// cycles until the reset output reaches lvl, capped at lim
	task automatic span(input logic lvl, input int lim, output int n);
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (rHi !== lvl && n < lim);
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
	endtask
	task automatic report_and_stop;
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ****
	// output forms, every cycle
	// ****
	always @(negedge clk_sys) begin
		if (wFired === 1'b1) fired++;
		samples_checked++;
		if (rLo !== ~rHi || rOe !== (odSel ? rHi : 1'b1)) begin
			n_mismatch++;
			$display("MISMATCH at %0t: got %h expected %h", $time, {rLo, rOe},
				{~rHi, (odSel ? rHi : 1'b1)});
		end
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		report_and_stop();
	end
	// ****
	// scenarios
	// ****
	initial begin
		int n;
		int len;
		int f0;
		{sys_rst, mrIn, mrOe, kickOn, kickDrv} = 5'h1F;
		{uv, odSel} = 4'h0;
		gap = 8'h10;
		cyc(4);
		sys_rst <= 1'b0;
		span(1'b0, 2000, n); chk(n, HOLD + 4, 3);
		for (int k = 0; k < 3; k++) begin
			len = 5 + ({$random(seed)} % 36);
			cyc(1);
			uv[k] <= 1'b1;
			span(1'b1, 50, n); chk(n, 4, 2);
			cyc(len);
			uv[k] <= 1'b0;
			span(1'b0, 2000, n); chk(n, HOLD + 4, 3);
		end
		cyc(1);
		uv[0] <= 1'b1;
		cyc(10);
		uv[0] <= 1'b0;
		cyc(10);
		uv[1] <= 1'b1;
		cyc(8);
		uv[1] <= 1'b0;
		span(1'b0, 2000, n); chk(n, HOLD + 4, 3);
		cyc(1);
		mrIn <= 1'b0;
		cyc(1);
		mrIn <= 1'b1;
		span(1'b1, 30, n); chk(n, 30, 0);
		cyc(1);
		mrIn <= 1'b0;
		span(1'b1, 40, n); chk(n, MRR + 6, 3);
		cyc(20);
		mrIn <= 1'b1;
		span(1'b0, 2000, n); chk(n, HOLD + 4, 3);
		cyc(1);
		{mrOe, mrIn} <= 2'b00;
		span(1'b1, 60, n); chk(n, 60, 0);
		cyc(1);
		{mrOe, mrIn} <= 2'b11;
		f0 = fired;
		kickOn <= 1'b0;
		uv[0] <= 1'b1;
		cyc(6);
		uv[0] <= 1'b0;
		span(1'b0, 2000, n);
		span(1'b1, 2000, n); chk(n, WDOG, 3);
		cyc(1);
		kickOn <= 1'b1;
		gap <= 8'(5 + ({$random(seed)} % 36));
		span(1'b0, 2000, n); chk(n, HOLD, 3);
		chk(fired - f0, 1, 0);
		span(1'b1, 300, n); chk(n, 300, 0);
		cyc(1);
		kickDrv <= 1'b0;
		span(1'b1, 300, n); chk(n, 300, 0);
		cyc(1);
		{sys_rst, odSel, kickDrv} <= 3'h7;
		cyc(4);
		sys_rst <= 1'b0;
		span(1'b0, 2000, n); chk(n, HOLD + 4, 3);
		cyc(1);
		uv[2] <= 1'b1;
		cyc(6);
		uv[2] <= 1'b0;
		span(1'b1, 50, n);
		span(1'b0, 2000, n); chk(n, HOLD + 1, 3);
		report_and_stop();
	end
endmodule
